/* File: dpram_pkg.sv */
// Shared constants for the dual-port block RAM with error correction.
// Assumes a single system clock and a classic Wishbone register slave.
package dpram_pkg;

   // Port arrangements
   localparam int MODE_SINGLE = 0;
   localparam int MODE_SIMPLE = 1;
   localparam int MODE_TRUE = 2;

   // Port indices inside the per-port arrays
   localparam int PORT_A = 0;
   localparam int PORT_B = 1;

   // Register map, byte addresses on the Wishbone bus
   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFS_ERR_ADDR = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;

   // Interrupt event layout: bit 2*port is single, 2*port+1 is double
   localparam int EV_W = 4;
   localparam int EV_SINGLE_OFS = 0;
   localparam int EV_DOUBLE_OFS = 1;

   // Reset values
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
   localparam logic CTRL_CORRECT_RESET = 1'b1;
   localparam int CTRL_CORRECT_BIT = 0;

   // Codeword bits flipped by the error injection inputs
   localparam int INJECT_BIT_0 = 1;
   localparam int INJECT_BIT_1 = 2;

endpackage

/* File: dual_port_ram_ecc.sv */
// Configurable block RAM with native ports A and B, optional output
// stages, byte writes, error correction and a Wishbone status slave.
// Assumes both ports and the bus share clk_sys_in; inputs synchronous.
`timescale 1ns/1ps

module dual_port_ram_ecc #(
   parameter int MODE = dpram_pkg::MODE_TRUE,
   parameter int DATA_W = 16,
   parameter int DEPTH = 16,
   parameter int OUT_STAGES = 0,
   parameter bit BYTE_WRITE = 1'b0,
   parameter int BYTE_W = 8,
   parameter bit ECC_EN = 1'b1,
   parameter int ADDR_W = $clog2(DEPTH),
   parameter int WE_W = BYTE_WRITE ? DATA_W / BYTE_W : 1
)(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic en_a_in,
   input wire logic [WE_W-1:0] we_a_in,
   input wire logic [ADDR_W-1:0] addr_a_in,
   input wire logic [DATA_W-1:0] din_a_in,
   input wire logic rst_a_in,
   input wire logic regce_a_in,
   input wire logic inject_single_in,
   input wire logic inject_double_in,
   input wire logic en_b_in,
   input wire logic [WE_W-1:0] we_b_in,
   input wire logic [ADDR_W-1:0] addr_b_in,
   input wire logic [DATA_W-1:0] din_b_in,
   input wire logic rst_b_in,
   input wire logic regce_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [dpram_pkg::WB_ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [dpram_pkg::WB_DAT_W-1:0] wb_dat_in,
   output logic [dpram_pkg::WB_DAT_W-1:0] wb_dat_out,
   output logic wb_ack_out,
   output logic irq_out,
   output logic [DATA_W-1:0] dout_a_out,
   output logic single_err_a_out,
   output logic double_err_a_out,
   output logic [ADDR_W-1:0] err_addr_a_out,
   output logic [DATA_W-1:0] dout_b_out,
   output logic single_err_b_out,
   output logic double_err_b_out,
   output logic [ADDR_W-1:0] err_addr_b_out
);

   // Parity bit count of the single-correct, double-detect code
   localparam int PAR_W = $clog2(DATA_W + 1 + $clog2(DATA_W + 1));
   localparam int CW = ECC_EN ? DATA_W + PAR_W + 1 : DATA_W;
   localparam int LAST = OUT_STAGES;

   // Refuse parameter sets the logic cannot serve
   generate
      if (MODE < dpram_pkg::MODE_SINGLE || MODE > dpram_pkg::MODE_TRUE) begin
         $error("MODE out of range");
      end
      if (OUT_STAGES < 0 || OUT_STAGES > 2) begin
         $error("OUT_STAGES must be 0, 1 or 2");
      end
      if (DEPTH < 2 || (1 << ADDR_W) != DEPTH) begin
         $error("DEPTH must be a power of two of at least 2");
      end
      if (BYTE_WRITE && (ECC_EN || DATA_W % BYTE_W != 0)) begin
         $error("Byte writes need whole bytes and no error correction");
      end
      if (WE_W != (BYTE_WRITE ? DATA_W / BYTE_W : 1)) begin
         $error("WE_W does not match the byte layout");
      end
   endgenerate

   // One output stage entry: data, flags and the address it came from
   typedef struct packed {
      logic sb;
      logic db;
      logic [ADDR_W-1:0] adr;
      logic [DATA_W-1:0] dat;
   } stage_s;

   // Whole module state
   typedef struct packed {
      logic [DEPTH-1:0][CW-1:0] mem;
      stage_s [1:0][LAST:0] pipe;
      logic [dpram_pkg::EV_W-1:0] irq_stat;
      logic [dpram_pkg::EV_W-1:0] irq_mask;
      logic correct;
      logic [ADDR_W-1:0] err_addr;
      logic wb_ack;
      logic [dpram_pkg::WB_DAT_W-1:0] wb_dat;
      logic irq;
   } state_s;

   state_s state;
   state_s next_state;

   logic [1:0] en;
   logic [1:0] rst_p;
   logic [1:0] regce;
   logic [1:0][WE_W-1:0] we;
   logic [1:0][ADDR_W-1:0] addr;
   logic [1:0][DATA_W-1:0] din;
   logic [1:0] port_on;
   logic [1:0] can_read;
   logic [1:0] can_write;
   logic [CW-1:0] wcw;
   logic [CW-1:0] inj;
   stage_s dec;
   logic [dpram_pkg::EV_W-1:0] ev;
   logic [dpram_pkg::EV_W-1:0] clr;
   logic wb_access;

   // Per-port arrays of the separate port inputs
   assign en = {en_b_in, en_a_in};
   assign rst_p = {rst_b_in, rst_a_in};
   assign regce = {regce_b_in, regce_a_in};
   assign we = {we_b_in, we_a_in};
   assign addr = {addr_b_in, addr_a_in};
   assign din = {din_b_in, din_a_in};

   // Port B write only in true dual
   // Port B absent in single port
   assign port_on[0] = 1'b1;
   assign port_on[1] = (MODE != dpram_pkg::MODE_SINGLE);
   assign can_read[0] = (MODE != dpram_pkg::MODE_SIMPLE);
   assign can_read[1] = (MODE != dpram_pkg::MODE_SINGLE);
   assign can_write[0] = 1'b1;
   assign can_write[1] = (MODE == dpram_pkg::MODE_TRUE);

   // Encode data into a codeword, overall parity at bit 0
   function automatic logic [CW-1:0] ecc_enc(input logic [DATA_W-1:0] d);
      logic [CW-1:0] c;
      int j;
      c = '0;
      j = 0;
      if (!ECC_EN) begin
         c = CW'(d);
      end else begin
         for (int i = 1; i < CW; i++) begin
            if ((i & (i - 1)) != 0) begin
               c[i] = d[j];
               j++;
            end
         end
         for (int i = 1; i < CW; i++) begin
            if ((i & (i - 1)) != 0) begin
               for (int b = 0; b < PAR_W; b++) begin
                  if (i[b]) begin
                     c[1 << b] = c[1 << b] ^ c[i];
                  end
               end
            end
         end
         c[0] = ^c;
      end
      return c;
   endfunction

   // Decode a codeword, fixing one flipped bit and flagging two
   function automatic stage_s ecc_dec(input logic [CW-1:0] c,
                                      input logic fix);
      stage_s r;
      logic [CW-1:0] w;
      int syn;
      int j;
      r = '0;
      w = c;
      syn = 0;
      j = 0;
      if (!ECC_EN) begin
         r.dat = w[DATA_W-1:0];
      end else begin
         for (int i = 1; i < CW; i++) begin
            if (c[i]) begin
               syn = syn ^ i;
            end
         end
         if (fix) begin
            if (^c && syn < CW) begin
               r.sb = 1'b1;
               if (syn != 0) begin
                  w[syn] = ~w[syn];
               end
            end else if (syn != 0) begin
               r.db = 1'b1;
            end
         end
         for (int i = 1; i < CW; i++) begin
            if ((i & (i - 1)) != 0) begin
               r.dat[j] = w[i];
               j++;
            end
         end
      end
      return r;
   endfunction

   // Next state of memory, output stages, registers and bus answer
   always_comb begin
      next_state = state;
      ev = '0;
      clr = '0;
      wcw = '0;
      inj = '0;
      dec = '0;
      wb_access = wb_cyc_in && wb_stb_in && !state.wb_ack;

      if (ECC_EN && inject_double_in) begin
         inj[dpram_pkg::INJECT_BIT_0] = 1'b1;
         inj[dpram_pkg::INJECT_BIT_1] = 1'b1;
      end else if (ECC_EN && inject_single_in) begin
         inj[dpram_pkg::INJECT_BIT_0] = 1'b1;
      end

      for (int p = 0; p < 2; p++) begin
         if (port_on[p] && en[p]) begin
            if (rst_p[p]) begin
               next_state.pipe[p][0] = '0;
            end else if (can_write[p] && (|we[p])) begin
               wcw = ecc_enc(din[p]);
               if (p == dpram_pkg::PORT_A) begin
                  wcw = wcw ^ inj;
               end
               if (BYTE_WRITE) begin
                  for (int b = 0; b < WE_W; b++) begin
                     if (we[p][b]) begin
                        next_state.mem[addr[p]][b*BYTE_W +: BYTE_W] =
                           wcw[b*BYTE_W +: BYTE_W];
                     end
                  end
               end else begin
                  next_state.mem[addr[p]] = wcw;
               end
            end else if (can_read[p]) begin
               dec = ecc_dec(state.mem[addr[p]], state.correct);
               dec.adr = addr[p];
               next_state.pipe[p][0] = dec;
               ev[2*p + dpram_pkg::EV_SINGLE_OFS] = dec.sb;
               ev[2*p + dpram_pkg::EV_DOUBLE_OFS] = dec.db;
               if (dec.sb || dec.db) begin
                  next_state.err_addr = addr[p];
               end
            end
         end

         // Output stages behind the first one
         for (int k = 1; k <= LAST; k++) begin
            if (port_on[p] && en[p]) begin
               if (k == LAST && rst_p[p]) begin
                  next_state.pipe[p][k] = '0;
               end else if (k < LAST || regce[p]) begin
                  next_state.pipe[p][k] = state.pipe[p][k-1];
               end
            end
         end
      end

      // Register bus: one-cycle ack, writes and reads
      next_state.wb_ack = wb_access;
      if (wb_access && wb_we_in && wb_sel_in[0]) begin
         unique case (wb_adr_in)
            dpram_pkg::OFS_IRQ_STATUS: clr = wb_dat_in[dpram_pkg::EV_W-1:0];
            dpram_pkg::OFS_IRQ_MASK:
               next_state.irq_mask = wb_dat_in[dpram_pkg::EV_W-1:0];
            dpram_pkg::OFS_CTRL:
               next_state.correct = wb_dat_in[dpram_pkg::CTRL_CORRECT_BIT];
            default: ;
         endcase
      end
      if (wb_access && !wb_we_in) begin
         unique case (wb_adr_in)
            dpram_pkg::OFS_IRQ_STATUS:
               next_state.wb_dat = 32'(state.irq_stat);
            dpram_pkg::OFS_IRQ_MASK: next_state.wb_dat = 32'(state.irq_mask);
            dpram_pkg::OFS_ERR_ADDR: next_state.wb_dat = 32'(state.err_addr);
            dpram_pkg::OFS_CTRL: next_state.wb_dat = 32'(state.correct);
            default: next_state.wb_dat = '0;
         endcase
      end

      // Sticky events: a new event wins over a same-cycle clear
      next_state.irq_stat = (state.irq_stat & ~clr) | ev;
      next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

      // Synchronous reset of control state; memory contents kept
      if (rst_in) begin
         next_state.pipe = '0;
         next_state.irq_stat = dpram_pkg::IRQ_STATUS_RESET;
         next_state.irq_mask = dpram_pkg::IRQ_MASK_RESET;
         next_state.correct = dpram_pkg::CTRL_CORRECT_RESET;
         next_state.err_addr = '0;
         next_state.wb_ack = 1'b0;
         next_state.wb_dat = '0;
         next_state.irq = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in) begin
      state <= next_state;
   end

   // Outputs from the last stage of each port
   assign dout_a_out = state.pipe[0][LAST].dat;
   assign single_err_a_out = state.pipe[0][LAST].sb;
   assign double_err_a_out = state.pipe[0][LAST].db;
   assign err_addr_a_out = state.pipe[0][LAST].adr;
   assign dout_b_out = state.pipe[1][LAST].dat;
   assign single_err_b_out = state.pipe[1][LAST].sb;
   assign double_err_b_out = state.pipe[1][LAST].db;
   assign err_addr_b_out = state.pipe[1][LAST].adr;
   assign wb_dat_out = state.wb_dat;
   assign wb_ack_out = state.wb_ack;
   assign irq_out = state.irq;

endmodule

/* File: ram_asserts.sv */
// Port and status-bus checks for the dual-port RAM.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ram_asserts #(
   parameter int DATA_W = 16,
   parameter int ADDR_W = 4,
   parameter int WE_W = 1,
   parameter int MODE = dpram_pkg::MODE_TRUE,
   parameter int OUT_STAGES = 0
)(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic en_a_in,
   input wire logic [WE_W-1:0] we_a_in,
   input wire logic [ADDR_W-1:0] addr_a_in,
   input wire logic rst_a_in,
   input wire logic en_b_in,
   input wire logic [WE_W-1:0] we_b_in,
   input wire logic [ADDR_W-1:0] addr_b_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic [DATA_W-1:0] dout_a_out,
   input wire logic single_err_a_out,
   input wire logic double_err_a_out,
   input wire logic [ADDR_W-1:0] err_addr_a_out,
   input wire logic [ADDR_W-1:0] err_addr_b_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // Request shapes on the bus and both ports
   sequence wb_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   // Reads that reach the outputs one clock later: no stages, port reads
   sequence rd_a;
      en_a_in && !rst_a_in && !(|we_a_in) && OUT_STAGES == 0
         && MODE != dpram_pkg::MODE_SIMPLE;
   endsequence
   sequence rd_b;
      en_b_in && !rst_b_in && !(|we_b_in) && OUT_STAGES == 0
         && MODE != dpram_pkg::MODE_SINGLE;
   endsequence
   ack_latency_a: assert property (wb_req |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held longer than one cycle");
   idle_hold_a: assert property (
      !en_a_in |=> $stable(dout_a_out) && $stable(err_addr_a_out))
      else $error("disabled port A changed its output");
   out_clear_a: assert property (
      en_a_in && rst_a_in |=> dout_a_out == '0 && !single_err_a_out)
      else $error("output reset left port A output set");
   wr_hold_a: assert property (
      en_a_in && !rst_a_in && (|we_a_in) |=> $stable(dout_a_out))
      else $error("write changed port A output");
   rd_addr_a: assert property (
      rd_a |=> err_addr_a_out == $past(addr_a_in))
      else $error("port A read address not reported");
   rd_addr_b: assert property (
      rd_b |=> err_addr_b_out == $past(addr_b_in))
      else $error("port B read address not reported");
   flag_excl_a: assert property (
      double_err_a_out |-> !single_err_a_out)
      else $error("double and single flags together");
endmodule
bind dual_port_ram_ecc ram_asserts #(
   .DATA_W(DATA_W), .ADDR_W(ADDR_W), .WE_W(WE_W), .MODE(MODE),
   .OUT_STAGES(OUT_STAGES)
) u_chk (
   .clk_sys_in, .rst_in, .en_a_in, .we_a_in, .addr_a_in, .rst_a_in,
   .en_b_in, .we_b_in, .addr_b_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
   .wb_ack_out, .dout_a_out, .single_err_a_out, .double_err_a_out,
   .err_addr_a_out, .err_addr_b_out
);

/* File: port_user.sv */
// User logic driving one native memory port.
// Assumes the testbench calls its task; shares the RAM clock.
`timescale 1ns/1ps
module port_user #(
   parameter int AW = 4,
   parameter int DW = 16
)(
   input wire logic clk_in,
   output logic en_out,
   output logic we_out,
   output logic rst_out,
   output logic regce_out,
   output logic [AW-1:0] addr_out,
   output logic [DW-1:0] din_out
);
   // Idle with the port disabled
   initial begin
      en_out = 1'b0;
      we_out = 1'b0;
      rst_out = 1'b0;
      regce_out = 1'b1;
      addr_out = '0;
      din_out = '0;
   end
   // same clock as the other port
   // One request for one edge, then release with controls low, address and data inverted
   task automatic access(input logic e, input logic w, input logic r,
         input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_in);
      en_out <= e;
      we_out <= w;
      rst_out <= r;
      addr_out <= a;
      din_out <= d;
      @(posedge clk_in);
      en_out <= 1'b0;
      we_out <= 1'b0;
      rst_out <= 1'b0;
      addr_out <= ~a;
      din_out <= ~d;
   endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the dual-port RAM with error correction.
// Assumes the RAM top, its checker bind and the port user model.
`timescale 1ns/1ps
module tb;
   logic clk_sys_in;
   logic rst_in;
   logic inj_s, inj_d, cyc, we, ack, irq;
   logic [7:0] adr;
   logic [31:0] wdat, dat, rdat;
   logic [1:0] en, wr, rs, rc;
   logic [3:0] ad [2];
   logic [15:0] di [2];
   logic [15:0] do_a, do_b;
   logic [3:0] ea_a, ea_b;
   logic se_a, de_a, se_b, de_b;
   int n_errors, n_checks;
   int mdl [16];
   logic [1:0] bwe;
   logic rce;
   logic [3:0] ra;
   logic [15:0] do2_a, do2_b;
   // Free-running system clock
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   dual_port_ram_ecc dut (.clk_sys_in, .rst_in,
      .en_a_in(en[0]), .we_a_in(wr[0]), .addr_a_in(ad[0]),
      .din_a_in(di[0]), .rst_a_in(rs[0]), .regce_a_in(rc[0]),
      .inject_single_in(inj_s), .inject_double_in(inj_d),
      .en_b_in(en[1]), .we_b_in(wr[1]), .addr_b_in(ad[1]),
      .din_b_in(di[1]), .rst_b_in(rs[1]), .regce_b_in(rc[1]),
      .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(dat),
      .wb_ack_out(ack), .irq_out(irq), .dout_a_out(do_a),
      .single_err_a_out(se_a), .double_err_a_out(de_a),
      .err_addr_a_out(ea_a), .dout_b_out(do_b),
      .single_err_b_out(se_b), .double_err_b_out(de_b),
      .err_addr_b_out(ea_b));
   // Simple dual port copy with byte writes and one output stage
   dual_port_ram_ecc #(.MODE(dpram_pkg::MODE_SIMPLE), .OUT_STAGES(1),
      .BYTE_WRITE(1'b1), .ECC_EN(1'b0)) dut2 (.clk_sys_in, .rst_in,
      .en_a_in(en[0]), .we_a_in(bwe & {2{wr[0]}}), .addr_a_in(ad[0]),
      .din_a_in(di[0]), .rst_a_in(rs[0]), .regce_a_in(rc[0]),
      .inject_single_in(1'b0), .inject_double_in(1'b0),
      .en_b_in(en[1]), .we_b_in({2{wr[1]}}), .addr_b_in(ad[1]),
      .din_b_in(di[1]), .rst_b_in(rs[1]), .regce_b_in(rce),
      .wb_cyc_in(1'b0), .wb_stb_in(1'b0), .wb_we_in(1'b0),
      .wb_adr_in(8'h0), .wb_sel_in(4'h0), .wb_dat_in(32'h0),
      .wb_dat_out(), .wb_ack_out(), .irq_out(), .dout_a_out(do2_a),
      .single_err_a_out(), .double_err_a_out(), .err_addr_a_out(),
      .dout_b_out(do2_b), .single_err_b_out(), .double_err_b_out(),
      .err_addr_b_out());
   port_user ua (.clk_in(clk_sys_in), .en_out(en[0]), .we_out(wr[0]),
      .rst_out(rs[0]), .regce_out(rc[0]), .addr_out(ad[0]),
      .din_out(di[0]));
   port_user ub (.clk_in(clk_sys_in), .en_out(en[1]), .we_out(wr[1]),
      .rst_out(rs[1]), .regce_out(rc[1]), .addr_out(ad[1]),
      .din_out(di[1]));
   task automatic chk(input string nm, input logic [31:0] s,
         input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Classic bus cycle held until ack, bounded wait
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk_sys_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (int i = 0; i < 8 && ack !== 1'b1; i++)
         @(posedge clk_sys_in);
      if (ack !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
      rdat = dat;
      cyc <= 1'b0;
   endtask
   // Same-cycle read on both ports, compared at the falling edge after the read edge
   task automatic rd2(input logic [3:0] a);
      fork
         ua.access(1'b1, 1'b0, 1'b0, a, 16'h0);
         ub.access(1'b1, 1'b0, 1'b0, a, 16'h0);
      join
      @(negedge clk_sys_in);
      chk("dout_a", 32'(do_a), 32'(mdl[a]));
      chk("dout_b", 32'(do_b), 32'(mdl[a]));
   endtask
   initial begin
      void'($urandom(32'hf2aacfd3));
      {n_errors, n_checks} = '0;
      rst_in = 1'b1;
      {inj_s, inj_d, cyc, we, adr, wdat} = '0;
      bwe = 2'b11;
      rce = 1'b1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("reset out", {do_a, do_b}, 32'h0);
      wb(1'b0, dpram_pkg::OFS_CTRL, 32'h0);
      chk("ctrl", rdat, 32'h1);
      wb(1'b1, dpram_pkg::OFS_IRQ_MASK, 32'h2);
      wb(1'b0, dpram_pkg::OFS_IRQ_MASK, 32'h0);
      chk("mask", rdat, 32'h2);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", rdat, 32'h0);
      for (int i = 0; i < 16; i++) begin
         mdl[i] = $urandom_range(16'hffff);
         ua.access(1'b1, 1'b1, 1'b0, 4'(i), 16'(mdl[i]));
      end
      for (int i = 0; i < 12; i++) begin
         ra = 4'($urandom_range(15));
         mdl[ra] = $urandom_range(16'hffff);
         ub.access(1'b1, 1'b1, 1'b0, ra, 16'(mdl[ra]));
         rd2(ra);
      end
      ua.access(1'b0, 1'b1, 1'b0, 4'h3, 16'h0);
      rd2(4'h3);
      ua.access(1'b1, 1'b0, 1'b1, 4'h4, 16'h0);
      @(negedge clk_sys_in);
      chk("out reset", 32'(do_a), 32'h0);
      rd2(4'h4);
      mdl[5] = 32'h5678;
      fork
         ua.access(1'b1, 1'b1, 1'b0, 4'h5, 16'h1234);
         ub.access(1'b1, 1'b1, 1'b0, 4'h5, 16'h5678);
      join
      rd2(4'h5);
      @(posedge clk_sys_in);
      inj_s <= 1'b1;
      ua.access(1'b1, 1'b1, 1'b0, 4'h7, 16'(mdl[7]));
      inj_s <= 1'b0;
      rd2(4'h7);
      chk("single", {se_a, de_a, se_b, de_b, ea_b}, 32'ha7);
      chk("masked irq", 32'(irq), 32'h0);
      @(posedge clk_sys_in);
      inj_d <= 1'b1;
      ua.access(1'b1, 1'b1, 1'b0, 4'h9, 16'(mdl[9]));
      inj_d <= 1'b0;
      rd2(4'h9);
      chk("double", {se_a, de_a, se_b, de_b, ea_a}, 32'h59);
      chk("irq", 32'(irq), 32'h1);
      wb(1'b0, dpram_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("status", rdat, 32'hf);
      wb(1'b1, dpram_pkg::OFS_IRQ_STATUS, 32'hf);
      wb(1'b0, dpram_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("cleared", {rdat[30:0], irq}, 32'h0);
      // Byte write on A, ignored B write and the output stage of dut2
      ua.access(1'b1, 1'b1, 1'b0, 4'h2, 16'ha5c3);
      bwe <= 2'b01;
      ua.access(1'b1, 1'b1, 1'b0, 4'h2, 16'h3c7e);
      bwe <= 2'b11;
      mdl[2] = 32'hffff;
      ub.access(1'b1, 1'b1, 1'b0, 4'h2, 16'hffff);
      ub.access(1'b1, 1'b0, 1'b1, 4'h2, 16'h0);
      ub.access(1'b1, 1'b0, 1'b0, 4'h2, 16'h0);
      @(negedge clk_sys_in);
      chk("stage early", 32'(do2_b), 32'h0);
      chk("dout_b write", 32'(do_b), 32'(mdl[2]));
      @(posedge clk_sys_in);
      rce <= 1'b0;
      ub.access(1'b1, 1'b0, 1'b0, 4'h2, 16'h0);
      @(negedge clk_sys_in);
      chk("regce held", 32'(do2_b), 32'h0);
      @(posedge clk_sys_in);
      rce <= 1'b1;
      ub.access(1'b1, 1'b0, 1'b0, 4'h2, 16'h0);
      @(negedge clk_sys_in);
      chk("byte write", 32'(do2_b), 32'ha57e);
      chk("no A read", 32'(do2_a), 32'h0);
      tally_and_finish();
   end
endmodule
